// ==== pkg/vto_pkg.sv ====
`default_nettype none
package vto_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] VTO_SEL_LO_ADR  = 8'h00;
  localparam logic [7:0] VTO_SEL_HI_ADR  = 8'h04;
  localparam logic [7:0] VTO_DRIVE_ADR   = 8'h08;
  localparam logic [7:0] VTO_CLKDIV_ADR  = 8'h0C;
  localparam logic [7:0] VTO_STATUS_ADR  = 8'h10;

  // Field positions
  localparam int VTO_SEL_W          = 4;
  localparam int VTO_DRV_A_BIT      = 8;
  localparam int VTO_DRV_B_BIT      = 9;
  localparam int VTO_DIV_A_LSB      = 0;
  localparam int VTO_DIV_B_LSB      = 2;
  localparam int VTO_DIV_D_LSB      = 4;
  localparam int VTO_ST_FMT_LSB     = 0;
  localparam int VTO_ST_DIV_LSB     = 8;
  localparam int VTO_ST_PHASE_LSB   = 16;

  // Timing source codes
  localparam logic [3:0] VTO_SRC_HSYNC    = 4'h0;
  localparam logic [3:0] VTO_SRC_HBLANK   = 4'h1;
  localparam logic [3:0] VTO_SRC_VSYNC    = 4'h2;
  localparam logic [3:0] VTO_SRC_VBLANK   = 4'h3;
  localparam logic [3:0] VTO_SRC_FSYNC    = 4'h4;
  localparam logic [3:0] VTO_SRC_FDIGITAL = 4'h5;
  localparam logic [3:0] VTO_SRC_ACTIVE   = 4'h6;
  localparam logic [3:0] VTO_SRC_FILM_ID  = 4'h7;
  localparam logic [3:0] VTO_SRC_AUDIO    = 4'h8;
  localparam logic [3:0] VTO_SRC_LAST     = 4'hC;
  localparam int         VTO_NUM_SRC      = 13;

  // Reset source per pin, pin 1 in the low nibble
  localparam logic [31:0] VTO_SEL_RESET = {
    VTO_SRC_ACTIVE, VTO_SRC_FILM_ID, VTO_SRC_FDIGITAL, VTO_SRC_FSYNC,
    VTO_SRC_VBLANK, VTO_SRC_VSYNC, VTO_SRC_HBLANK, VTO_SRC_HSYNC};

  // Divide ratio codes
  localparam logic [1:0] VTO_DIV1 = 2'h0;
  localparam logic [1:0] VTO_DIV2 = 2'h1;
  localparam logic [1:0] VTO_DIV4 = 2'h2;

  // Phase after which all divided clocks rise together
  localparam logic [2:0] VTO_PHASE_WRAP = 3'h7;
  localparam logic [5:0] VTO_FMT_OFF    = 6'h00;

  // Generated timing signals, hsync in bit 0
  typedef struct packed {
    logic [3:0] custom;
    logic       audio_frame_sync;
    logic       film_cadence_field_id;
    logic       active_video_flag;
    logic       field_digital;
    logic       field_sync;
    logic       vblank;
    logic       vsync;
    logic       hblank;
    logic       hsync;
  } vto_sources_t;

  // Wishbone request group
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } vto_wb_req_t;

endpackage
`default_nettype wire

// ==== src/vto_output_stage.sv ====
// How it works
// - Each of the eight timing pins drives the generated signal that its select field names.
// - After reset the sixth timing pin carries the field digital signal.
// - After reset the seventh timing pin carries the ten-field film cadence identifier.
// - After reset the eighth timing pin carries the active-video flag.
// - All timing pins are released (high impedance) while the format select is zero.
// - Timing pins update only on fundamental rising edges, in step with the video clocks.
// - Each timing pin has a drive-strength bit that resets to low.
// - The differential clock resets to the undivided fundamental rate.
// - Single-ended clock b resets to the undivided fundamental rate.
// - The differential clock divide ratio is software selectable as 1, 2 or 4.
// - Clock b has its own software selectable divide ratio of 1, 2 or 4.
// - The differential clock pair is released while the format select is zero.
// - Clock b is held low, still driven, while the format select is zero.
// - Clock b has a drive-strength bit that resets to low.
// - Clock a is held low while the format select is zero.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module vto_output_stage
  import vto_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Wishbone slave
  input  wire vto_wb_req_t  wb_req_i,
  output logic              wb_ack_o,
  output logic [31:0]       wb_dat_o,
  // Fundamental clock edges and generated timing
  input  wire logic         fund_tick_i,
  input  wire vto_sources_t timing_src_i,
  input  wire logic [5:0]   format_select_pins_i,
  // Timing output pins
  output logic [7:0]        timing_o,
  output logic [7:0]        timing_oe_n_o,
  output logic [7:0]        timing_drive_hi_o,
  // Video clock outputs
  output logic              video_clock_out_a_o,
  output logic              video_clock_out_b_o,
  output logic              video_clock_out_diff_p_o,
  output logic              video_clock_out_diff_n_o,
  output logic              video_clock_out_diff_oe_n_o,
  output logic              clk_a_drive_hi_o,
  output logic              clk_b_drive_hi_o
);

  typedef struct packed {
    logic [31:0] sel;
    logic [7:0]  drv_timing;
    logic        drv_a;
    logic        drv_b;
    logic [1:0]  req_a;
    logic [1:0]  req_b;
    logic [1:0]  req_d;
    logic [1:0]  div_a;
    logic [1:0]  div_b;
    logic [1:0]  div_d;
    logic [2:0]  phase;
    logic [7:0]  timing;
    logic [7:0]  timing_oe_n;
    logic        clk_a;
    logic        clk_b;
    logic        clk_p;
    logic        clk_n;
    logic        clk_d_oe_n;
    logic        ack;
    logic [31:0] rdata;
  } vto_state_t;

  vto_state_t                 st;
  vto_state_t                 next_st;
  logic [VTO_NUM_SRC-1:0]     src_vec;
  logic                       fmt_off;

  // Clock level for a phase and ratio; all ratios rise at even phases
  function automatic logic div_level(input logic [2:0] ph, input logic [1:0] dv);
    logic lvl;
    lvl = ~ph[0];
    if (dv == VTO_DIV2) begin
      lvl = ~ph[1];
    end else if (dv == VTO_DIV4) begin
      lvl = ~ph[2];
    end
    return lvl;
  endfunction

  // Merge a write into a word under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign src_vec = timing_src_i;
  assign fmt_off = (format_select_pins_i == VTO_FMT_OFF);

  // Next state: bus slave, divider and pin logic
  always_comb begin
    logic [31:0] drv_word;
    logic [31:0] div_word;
    logic [31:0] w;
    logic        access;
    logic [2:0]  ph;
    drv_word = '0;
    div_word = '0;
    w        = '0;
    access   = 1'b0;
    ph       = st.phase;
    next_st  = st;

    drv_word[7:0]           = st.drv_timing;
    drv_word[VTO_DRV_A_BIT] = st.drv_a;
    drv_word[VTO_DRV_B_BIT] = st.drv_b;
    div_word[VTO_DIV_A_LSB +: 2] = st.req_a;
    div_word[VTO_DIV_B_LSB +: 2] = st.req_b;
    div_word[VTO_DIV_D_LSB +: 2] = st.req_d;

    // Ack one cycle after the request; drops the cycle after
    access     = wb_req_i.cyc && wb_req_i.stb;
    next_st.ack = access && !st.ack;
    if (access && !st.ack) begin
      unique case (wb_req_i.adr)
        VTO_SEL_LO_ADR: next_st.rdata = {16'h0000, st.sel[15:0]};
        VTO_SEL_HI_ADR: next_st.rdata = {16'h0000, st.sel[31:16]};
        VTO_DRIVE_ADR:  next_st.rdata = drv_word;
        VTO_CLKDIV_ADR: next_st.rdata = div_word;
        VTO_STATUS_ADR: begin
          next_st.rdata = '0;
          next_st.rdata[VTO_ST_FMT_LSB +: 6]   = format_select_pins_i;
          next_st.rdata[VTO_ST_DIV_LSB +: 6]   = {st.div_d, st.div_b, st.div_a};
          next_st.rdata[VTO_ST_PHASE_LSB +: 3] = st.phase;
        end
        default:        next_st.rdata = '0;
      endcase
    end

    // Writes land at the edge where the master sees ack
    if (access && st.ack && wb_req_i.we) begin
      unique case (wb_req_i.adr)
        VTO_SEL_LO_ADR: begin
          w = merge({16'h0000, st.sel[15:0]}, wb_req_i.dat, wb_req_i.sel);
          next_st.sel[15:0] = w[15:0];
        end
        VTO_SEL_HI_ADR: begin
          w = merge({16'h0000, st.sel[31:16]}, wb_req_i.dat, wb_req_i.sel);
          next_st.sel[31:16] = w[15:0];
        end
        VTO_DRIVE_ADR: begin
          w = merge(drv_word, wb_req_i.dat, wb_req_i.sel);
          next_st.drv_timing = w[7:0];
          next_st.drv_a      = w[VTO_DRV_A_BIT];
          next_st.drv_b      = w[VTO_DRV_B_BIT];
        end
        VTO_CLKDIV_ADR: begin
          w = merge(div_word, wb_req_i.dat, wb_req_i.sel);
          next_st.req_a = w[VTO_DIV_A_LSB +: 2];
          next_st.req_b = w[VTO_DIV_B_LSB +: 2];
          next_st.req_d = w[VTO_DIV_D_LSB +: 2];
        end
        default: begin
          w = '0;
        end
      endcase
    end

    // Ratios switch only at the wrap, when every clock rises together
    if (fund_tick_i) begin
      ph = st.phase + 3'h1;
      next_st.phase = ph;
      if (st.phase == VTO_PHASE_WRAP) begin
        // Code 3 falls back to the undivided rate
        next_st.div_a = (st.req_a == 2'h3) ? VTO_DIV1 : st.req_a;
        next_st.div_b = (st.req_b == 2'h3) ? VTO_DIV1 : st.req_b;
        next_st.div_d = (st.req_d == 2'h3) ? VTO_DIV1 : st.req_d;
      end
    end

    // Divided clock levels; a and b forced low when format is off
    next_st.clk_a = !fmt_off && div_level(next_st.phase, next_st.div_a);
    next_st.clk_b = !fmt_off && div_level(next_st.phase, next_st.div_b);
    next_st.clk_p = div_level(next_st.phase, next_st.div_d);
    next_st.clk_n = ~div_level(next_st.phase, next_st.div_d);
    next_st.clk_d_oe_n = fmt_off;

    // Timing pins follow their source on fundamental rising edges
    for (int p = 0; p < 8; p++) begin
      if (fund_tick_i && !ph[0]) begin
        if (st.sel[p*VTO_SEL_W +: VTO_SEL_W] <= VTO_SRC_LAST) begin
          next_st.timing[p] = src_vec[st.sel[p*VTO_SEL_W +: VTO_SEL_W]];
        end else begin
          next_st.timing[p] = 1'b0;
        end
      end
      next_st.timing_oe_n[p] = fmt_off;
    end
  end

  // State register; defaults per pin and undivided clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st             <= '0;
      st.sel         <= VTO_SEL_RESET;
      st.req_a       <= VTO_DIV1;
      st.req_b       <= VTO_DIV1;
      st.req_d       <= VTO_DIV1;
      st.div_a       <= VTO_DIV1;
      st.div_b       <= VTO_DIV1;
      st.div_d       <= VTO_DIV1;
      st.timing_oe_n <= 8'hFF;
      st.clk_d_oe_n  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o                    = st.ack;
  assign wb_dat_o                    = st.rdata;
  assign timing_o                    = st.timing;
  assign timing_oe_n_o               = st.timing_oe_n;
  assign timing_drive_hi_o           = st.drv_timing;
  assign video_clock_out_a_o         = st.clk_a;
  assign video_clock_out_b_o         = st.clk_b;
  assign video_clock_out_diff_p_o    = st.clk_p;
  assign video_clock_out_diff_n_o    = st.clk_n;
  assign video_clock_out_diff_oe_n_o = st.clk_d_oe_n;
  assign clk_a_drive_hi_o            = st.drv_a;
  assign clk_b_drive_hi_o            = st.drv_b;

  // Checks on the pin and clock behaviour
  // Reset values are looked at on the first edge after release only
  timing_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fund_tick_i && st.phase[0] && st.sel[3:0] <= VTO_SRC_LAST)
    |=> timing_o[0] == $past(src_vec[st.sel[3:0]]))
    else $error("timing pin 1 missed its source");

  reset_sel_a: assert property (@(posedge clk_i)
    !rst_i && $past(rst_i) |-> st.sel[23:20] == VTO_SRC_FDIGITAL)
    else $error("pin 6 reset source wrong");

  film_sel_a: assert property (@(posedge clk_i)
    !rst_i && $past(rst_i) |-> st.sel[27:24] == VTO_SRC_FILM_ID)
    else $error("pin 7 reset source wrong");

  active_sel_a: assert property (@(posedge clk_i)
    !rst_i && $past(rst_i) |-> st.sel[31:28] == VTO_SRC_ACTIVE)
    else $error("pin 8 reset source wrong");

  timing_tri_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_off |=> timing_oe_n_o == 8'hFF)
    else $error("timing pins driven with format off");

  timing_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(timing_o) |-> $past(fund_tick_i) && !st.phase[0])
    else $error("timing change off the clock edge");

  drive_reset_a: assert property (@(posedge clk_i)
    !rst_i && $past(rst_i) |-> timing_drive_hi_o == 8'h00 && !clk_b_drive_hi_o)
    else $error("drive strength not low after reset");

  div_reset_a: assert property (@(posedge clk_i)
    !rst_i && $past(rst_i) |-> st.div_d == VTO_DIV1 && st.div_b == VTO_DIV1)
    else $error("clocks not undivided after reset");

  div_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fund_tick_i && st.div_d == VTO_DIV2 && st.phase[1:0] == 2'h1)
    |=> !video_clock_out_diff_p_o ##0 video_clock_out_diff_n_o)
    else $error("diff clock divide by two wrong");

  b_ratio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fund_tick_i && st.div_b == VTO_DIV4 && st.phase == 3'h3 && !fmt_off)
    |=> !video_clock_out_b_o)
    else $error("clock b divide by four wrong");

  diff_tri_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_off |=> video_clock_out_diff_oe_n_o)
    else $error("diff clock driven with format off");

  b_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_off |=> !video_clock_out_b_o)
    else $error("clock b not low with format off");

  a_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fmt_off |=> !video_clock_out_a_o)
    else $error("clock a not low with format off");

  div_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(st.div_a) || $changed(st.div_b) || $changed(st.div_d))
    |-> $past(fund_tick_i) && $past(st.phase) == VTO_PHASE_WRAP)
    else $error("ratio switched away from the wrap");

  // Checks on pin enables, undivided rates and the divider phase
  pins_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fmt_off |=> timing_oe_n_o == 8'h00)
    else $error("timing pins released with format on");

  diff_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fmt_off |=> !video_clock_out_diff_oe_n_o)
    else $error("diff clock released with format on");

  timing_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !fund_tick_i |=> $stable(timing_o))
    else $error("timing pin moved without a fundamental edge");

  diff_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> video_clock_out_diff_n_o != video_clock_out_diff_p_o)
    else $error("diff clock pair not complementary");

  diff_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fund_tick_i && st.div_d == VTO_DIV1 && st.phase != VTO_PHASE_WRAP)
    |=> video_clock_out_diff_p_o == !st.phase[0])
    else $error("diff clock not at the fundamental rate");

  b_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fund_tick_i && st.div_b == VTO_DIV1 && st.phase != VTO_PHASE_WRAP && !fmt_off)
    |=> video_clock_out_b_o == !st.phase[0])
    else $error("clock b not at the fundamental rate");

  edge_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fund_tick_i && st.phase == VTO_PHASE_WRAP && !fmt_off)
    |=> video_clock_out_a_o && video_clock_out_b_o && video_clock_out_diff_p_o)
    else $error("divided clocks not rising together at the wrap");

  phase_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fund_tick_i |=> st.phase == $past(st.phase) + 3'h1)
    else $error("divider phase skipped a step");

  // Settings may move only at the edge where a write is acknowledged
  sel_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_ack_o && wb_req_i.we) |=> $stable(st.sel))
    else $error("pin select changed without a write");

  drive_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_ack_o && wb_req_i.we) |=> $stable({timing_drive_hi_o, clk_b_drive_hi_o}))
    else $error("drive strength changed without a write");

endmodule
`default_nettype wire

// ==== tb/video_timing_clock_output_stage_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module video_timing_clock_output_stage_bench;
  import vto_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  vto_wb_req_t  wb_req = '0;
  vto_sources_t src = '0;
  logic fund_tick = 1'b0;
  logic [5:0] fmt = 6'h05;
  logic wb_ack_o, clk_a, clk_b, clk_p, clk_n, d_oe_n, drv_a, drv_b;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic [7:0] timing, t_oe_n, t_drv;
  logic [15:0] ra, rb, rdf, skew, sa, sb, sd;
  int fail_count = 0;
  int checks = 0;
  int cyc_n = 0;

  vto_output_stage u_vto_output_stage (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .fund_tick_i(fund_tick), .timing_src_i(src),
    .format_select_pins_i(fmt), .timing_o(timing), .timing_oe_n_o(t_oe_n),
    .timing_drive_hi_o(t_drv), .video_clock_out_a_o(clk_a), .video_clock_out_b_o(clk_b),
    .video_clock_out_diff_p_o(clk_p), .video_clock_out_diff_n_o(clk_n),
    .video_clock_out_diff_oe_n_o(d_oe_n), .clk_a_drive_hi_o(drv_a), .clk_b_drive_hi_o(drv_b));
  vto_video_sink u_vto_video_sink (.clk_i(clk_i), .rst_i(rst_i), .timing_i(timing),
    .clk_a_i(clk_a), .clk_b_i(clk_b), .clk_d_i(clk_p), .rise_a_o(ra), .rise_b_o(rb),
    .rise_d_o(rdf), .skew_o(skew));

  // 125 MHz clock
  always #4 clk_i = ~clk_i;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] wdat);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wdat};
    // Ack is sampled at the rising edge; the hang guard ends a lost answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
  endtask

  // Fundamental edges, one pulse every other cycle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      fund_tick <= 1'b1;
      @(posedge clk_i);
      fund_tick <= 1'b0;
    end
    @(negedge clk_i);
  endtask

  function automatic logic [7:0] exp_t(input logic [31:0] sel, input vto_sources_t s);
    logic [7:0] r;
    logic [3:0] c;
    for (int p = 0; p < 8; p++) begin
      c = sel[4*p +: 4];
      r[p] = (c <= VTO_SRC_LAST) ? s[c] : 1'b0;
    end
    return r;
  endfunction

  // Walk a single active source past every pin for a select map
  task automatic scan_sources(input logic [31:0] sel);
    for (int k = 0; k < VTO_NUM_SRC; k++) begin
      @(posedge clk_i);
      src <= vto_sources_t'(13'h0001 << k);
      tick(2);
      chk("timing_o", {24'h0, exp_t(sel, vto_sources_t'(13'h0001 << k))}, {24'h0, timing});
    end
  endtask

  // Count clock rises over n fundamental edges; a settle cycle on each side
  // keeps an edge launched before or at the end of the window counted once
  task automatic rises(input int n, input logic [15:0] ea, eb, ed);
    @(posedge clk_i);
    @(negedge clk_i);
    sa = ra;
    sb = rb;
    sd = rdf;
    tick(n);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("rises_a", {16'h0, ea}, {16'h0, ra - sa});
    chk("rises_b", {16'h0, eb}, {16'h0, rb - sb});
    chk("rises_diff", {16'h0, ed}, {16'h0, rdf - sd});
  endtask

  task automatic reset_values;
    wb(1'b0, VTO_SEL_LO_ADR, 4'hF, 32'h0);
    chk("sel_lo", {16'h0, VTO_SEL_RESET[15:0]}, rd);
    wb(1'b0, VTO_SEL_HI_ADR, 4'hF, 32'h0);
    chk("sel_hi", {16'h0, VTO_SEL_RESET[31:16]}, rd);
    wb(1'b0, VTO_DRIVE_ADR, 4'hF, 32'h0);
    chk("drive", 32'h0, rd);
    chk("drive_pins", 32'h0, {22'h0, drv_b, drv_a, t_drv});
    wb(1'b0, VTO_CLKDIV_ADR, 4'hF, 32'h0);
    chk("ratios", 32'h0, rd);
    wb(1'b0, 8'h20, 4'hF, 32'h0);
    chk("unmapped", 32'h0, rd);
    scan_sources(VTO_SEL_RESET);
    rises(8, 16'h4, 16'h4, 16'h4);
  endtask

  task automatic reselect;
    wb(1'b1, VTO_SEL_LO_ADR, 4'hF, 32'h0000BA98);
    wb(1'b1, VTO_SEL_HI_ADR, 4'hF, 32'h00000FDC);
    scan_sources(32'h0FDCBA98);
  endtask

  task automatic drive_bits;
    wb(1'b1, VTO_DRIVE_ADR, 4'h3, 32'h000003FF);
    @(negedge clk_i);
    chk("drive_pins", 32'h3FF, {22'h0, drv_b, drv_a, t_drv});
    wb(1'b1, VTO_DRIVE_ADR, 4'h2, 32'h0);
    @(negedge clk_i);
    chk("drive_lane", 32'h0FF, {22'h0, drv_b, drv_a, t_drv});
    wb(1'b1, VTO_STATUS_ADR, 4'hF, 32'hFFFFFFFF);
    wb(1'b0, VTO_STATUS_ADR, 4'hF, 32'h0);
    chk("status_fmt", {26'h0, fmt}, {26'h0, rd[5:0]});
  endtask

  task automatic divide;
    wb(1'b1, VTO_CLKDIV_ADR, 4'hF, 32'h00000024);
    tick(10);
    wb(1'b0, VTO_STATUS_ADR, 4'hF, 32'h0);
    chk("applied", 32'h24, {26'h0, rd[13:8]});
    rises(16, 16'h8, 16'h4, 16'h2);
    chk("diff_n", {31'h0, ~clk_p}, {31'h0, clk_n});
    // Swap the ratios so clock b runs at a quarter and the pair at half
    wb(1'b1, VTO_CLKDIV_ADR, 4'hF, 32'h00000018);
    tick(10);
    wb(1'b0, VTO_STATUS_ADR, 4'hF, 32'h0);
    chk("applied", 32'h18, {26'h0, rd[13:8]});
    rises(16, 16'h8, 16'h2, 16'h4);
  endtask

  task automatic format_off;
    @(posedge clk_i);
    fmt <= VTO_FMT_OFF;
    // Released pair keeps toggling at half rate; a and b stay low
    rises(8, 16'h0, 16'h0, 16'h2);
    chk("oe_off", 32'h1FF, {23'h0, d_oe_n, t_oe_n});
    chk("clk_b_low", 32'h0, {31'h0, clk_b});
    @(posedge clk_i);
    fmt <= 6'h05;
    tick(2);
    chk("oe_on", 32'h0, {23'h0, d_oe_n, t_oe_n});
  endtask

  task automatic give_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    reselect();
    drive_bits();
    divide();
    format_off();
    chk("skew", 32'h0, {16'h0, skew});
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== tb/vto_video_sink.sv ====
`timescale 1ns/1ns
`default_nettype none
module vto_video_sink (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Outputs of the stage, as the application side sees them
  input  wire logic [7:0]  timing_i,
  input  wire logic        clk_a_i,
  input  wire logic        clk_b_i,
  input  wire logic        clk_d_i,
  // Edge counts and misaligned timing moves
  output logic [15:0]      rise_a_o,
  output logic [15:0]      rise_b_o,
  output logic [15:0]      rise_d_o,
  output logic [15:0]      skew_o
);
  logic [7:0] last_t;
  logic       last_a;
  logic       last_b;
  logic       last_d;
  // Receiver samples timing on clock a, so a move without a rising edge is a skew
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_a_o <= 16'h0000;
      rise_b_o <= 16'h0000;
      rise_d_o <= 16'h0000;
      skew_o   <= 16'h0000;
    end else begin
      rise_a_o <= rise_a_o + {15'h0000, clk_a_i & ~last_a};
      rise_b_o <= rise_b_o + {15'h0000, clk_b_i & ~last_b};
      rise_d_o <= rise_d_o + {15'h0000, clk_d_i & ~last_d};
      if (timing_i != last_t && !(clk_a_i && !last_a)) begin
        skew_o <= skew_o + 16'h0001;
      end
    end
    last_t <= timing_i;
    last_a <= clk_a_i;
    last_b <= clk_b_i;
    last_d <= clk_d_i;
  end
endmodule
`default_nettype wire
